// >>> rtl/pbts_pkg.sv
// constants, field layout and bus carrier types for the port b trigger-select block
// assumes a single ahb-lite slave port on a 20 MHz core clock
// Operation
// - code 00 requests on high input level, code 01 on low level.
// - code 10 requests on rising edge, code 11 on falling edge.
// - upper register at 0x238 holds lines 31..16, two bits per line.
// - lower register at 0x23C holds line 15 in bits 31:30.
// - every trigger field resets to zero, meaning high level sensing.
// - fields are read/write; reads return last write, no side effects.
package pbts_pkg;

  localparam int unsigned  LINE_LO       = 15;
  localparam int unsigned  LINE_HI       = 31;
  localparam int unsigned  UPPER_BASE    = 16;
  localparam int unsigned  ADDR_W        = 12;
  localparam int unsigned  LOWER_FLD_LSB = 30;

  localparam logic [11:0]  OFS_TRIG_UPPER = 12'h238;
  localparam logic [11:0]  OFS_TRIG_LOWER = 12'h23C;
  localparam logic [11:0]  OFS_STATUS     = 12'h240;
  localparam logic [11:0]  OFS_MASK       = 12'h244;
  localparam logic [11:0]  OFS_LEVEL      = 12'h248;

  localparam logic [31:0]  RST_TRIG_UPPER = 32'h0000_0000;
  localparam logic [31:0]  RST_TRIG_LOWER = 32'h0000_0000;
  localparam logic [31:0]  RST_STATUS     = 32'h0000_0000;
  localparam logic [31:0]  RST_MASK       = 32'h0000_0000;
  localparam logic [31:0]  LOWER_RW_MASK  = 32'hC000_0000;
  localparam logic [31:0]  LINE_BITS_MASK = 32'hFFFF_8000;

  localparam logic [1:0]   HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]   HTRANS_SEQ     = 2'h3;

  typedef enum logic [1:0] {
    TRIG_LEVEL_HIGH = 2'b00,
    TRIG_LEVEL_LOW  = 2'b01,
    TRIG_RISE       = 2'b10,
    TRIG_FALL       = 2'b11
  } pbts_trig_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } pbts_addr_ph_t;

  localparam pbts_addr_ph_t ADDR_PH_IDLE = '{valid: 1'b0, write: 1'b0, addr: 12'h000};

endpackage : pbts_pkg

// >>> rtl/pbts_top.sv
// port b interrupt trigger selection with sticky status, mask and one irq line
// assumes ahb-lite master, single word transfers, pins asynchronous to hclk
`timescale 1ns/1ns
module pbts_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire logic [pbts_pkg::LINE_HI:pbts_pkg::LINE_LO] port_b_lines,
  output logic                       irq
);
  import pbts_pkg::*;

  localparam int unsigned NL = LINE_HI - LINE_LO + 1;

  // trigger code of line n out of the two trigger-select registers
  function automatic logic [1:0] line_code(input logic [31:0] up,
                                           input logic [31:0] lo,
                                           input int unsigned n);
    logic [1:0] c;
    c = lo[LOWER_FLD_LSB +: 2];
    if (n >= UPPER_BASE) begin
      c = up[2*(n-UPPER_BASE) +: 2];
    end
    return c;
  endfunction : line_code

  // request of one line for its code, current and previous sampled level
  function automatic logic detect(input logic [1:0] code, input logic cur,
                                  input logic prev);
    logic r;
    r = 1'b0;
    unique case (pbts_trig_t'(code))
      TRIG_LEVEL_HIGH: r = cur;
      TRIG_LEVEL_LOW:  r = ~cur;
      TRIG_RISE:       r = cur & ~prev;
      TRIG_FALL:       r = ~cur & prev;
    endcase
    return r;
  endfunction : detect

  logic [31:0]    trig_upper;
  logic [31:0]    trig_lower;
  logic [NL-1:0]  status;
  logic [NL-1:0]  mask;
  logic [NL-1:0]  sync1;
  logic [NL-1:0]  sync2;
  logic [NL-1:0]  prev;
  pbts_addr_ph_t  aph;

  logic [31:0]    next_trig_upper;
  logic [31:0]    next_trig_lower;
  logic [NL-1:0]  next_status;
  logic [NL-1:0]  next_mask;
  logic [31:0]    next_hrdata;
  pbts_addr_ph_t  next_aph;
  logic [NL-1:0]  evt;
  logic [NL-1:0]  w1c;
  logic [31:0]    rd_word;

  // bus decode
  wire take       = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == HTRANS_SEQ);
  wire wr_dp      = aph.valid & aph.write;
  wire wr_upper   = wr_dp & (aph.addr == OFS_TRIG_UPPER);
  wire wr_lower   = wr_dp & (aph.addr == OFS_TRIG_LOWER);
  wire wr_status  = wr_dp & (aph.addr == OFS_STATUS);
  wire wr_mask    = wr_dp & (aph.addr == OFS_MASK);
  wire rd_take    = take & ~hwrite;
  wire [ADDR_W-1:0] rd_addr = haddr[ADDR_W-1:0];

  assign next_aph = take ? '{valid: 1'b1, write: hwrite, addr: haddr[ADDR_W-1:0]}
                         : ADDR_PH_IDLE;

  // writes land in the data phase; only whole-word transfers are expected
  assign next_trig_upper = wr_upper ? hwdata : trig_upper;
  assign next_trig_lower = wr_lower ? (hwdata & LOWER_RW_MASK) : trig_lower;
  assign next_mask       = wr_mask ? hwdata[LINE_HI:LINE_LO] : mask;
  assign w1c             = wr_status ? hwdata[LINE_HI:LINE_LO] : '0;

  // edge and level detection on the synchronised levels
  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_det
      assign evt[gi] = detect(line_code(trig_upper, trig_lower, gi + LINE_LO),
                              sync2[gi], prev[gi]);
    end
  endgenerate

  // a new event in the clearing cycle keeps its bit set
  assign next_status = (status & ~w1c) | evt;

  // reads see the value after a write in the same cycle, so back to back
  // write then read of one register returns the new data
  assign rd_word = (rd_addr == OFS_TRIG_UPPER) ? next_trig_upper :
                   (rd_addr == OFS_TRIG_LOWER) ? next_trig_lower :
                   (rd_addr == OFS_STATUS)     ? {next_status, 15'h0000} :
                   (rd_addr == OFS_MASK)       ? {next_mask, 15'h0000} :
                   (rd_addr == OFS_LEVEL)      ? {sync2, 15'h0000} : 32'h0000_0000;
  assign next_hrdata = rd_take ? rd_word : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_upper <= RST_TRIG_UPPER;
      trig_lower <= RST_TRIG_LOWER;
      status     <= RST_STATUS[LINE_HI:LINE_LO];
      mask       <= RST_MASK[LINE_HI:LINE_LO];
      aph        <= ADDR_PH_IDLE;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      irq        <= 1'b0;
    end else begin
      trig_upper <= next_trig_upper;
      trig_lower <= next_trig_lower;
      status     <= next_status;
      mask       <= next_mask;
      aph        <= next_aph;
      hrdata     <= next_hrdata;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      irq        <= |(next_status & next_mask);
    end
  end

  // pins are asynchronous; sync1 feeds only sync2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= port_b_lines;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // helper state for the checks below
  logic          written_any;
  logic [NL-1:0] want_hi;
  logic [NL-1:0] want_lo;
  logic [NL-1:0] want_rise;
  logic [NL-1:0] want_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      written_any <= 1'b0;
    end else if (wr_upper | wr_lower) begin
      written_any <= 1'b1;
    end
  end

  generate
    for (gi = 0; gi < NL; gi++) begin : g_want
      wire [1:0] cd = line_code(trig_upper, trig_lower, gi + LINE_LO);
      assign want_hi[gi]   = (cd == TRIG_LEVEL_HIGH) & sync2[gi];
      assign want_lo[gi]   = (cd == TRIG_LEVEL_LOW) & ~sync2[gi];
      assign want_rise[gi] = (cd == TRIG_RISE) & sync2[gi] & ~prev[gi];
      assign want_fall[gi] = (cd == TRIG_FALL) & ~sync2[gi] & prev[gi];
    end
  endgenerate

  // helper views so the checks below do not lean on the design's own decode
  logic [NL-1:0] wd_lines;
  logic [NL-1:0] want_any;
  logic          rd_mapped;

  assign wd_lines  = hwdata[LINE_HI:LINE_LO];
  assign want_any  = want_hi | want_lo | want_rise | want_fall;
  assign rd_mapped = (rd_addr == OFS_TRIG_UPPER) |
                     (rd_addr == OFS_TRIG_LOWER) |
                     (rd_addr == OFS_STATUS) |
                     (rd_addr == OFS_MASK) |
                     (rd_addr == OFS_LEVEL);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_level_high_set: assert property (
    |want_hi |=> ((status & $past(want_hi)) == $past(want_hi)))
    else $error("high level did not set status");

  chk_level_low_set: assert property (
    |want_lo |=> ((status & $past(want_lo)) == $past(want_lo)))
    else $error("low level did not set status");

  chk_edge_set: assert property (
    |(want_rise | want_fall) |=>
      ((status & $past(want_rise | want_fall)) == $past(want_rise | want_fall)))
    else $error("edge did not set status");

  chk_edge_quiet: assert property (
    (trig_upper == 32'hAAAA_AAAA) && (sync2 == prev) && !wr_status && !wr_upper
      |=> (status[NL-1:1] == $past(status[NL-1:1])))
    else $error("status changed without an edge");

  chk_upper_write: assert property (
    wr_upper |=> (trig_upper == $past(hwdata)))
    else $error("upper trigger register not written");

  chk_lower_write: assert property (
    wr_lower |=> (trig_lower[31:30] == $past(hwdata[31:30])) && (trig_lower[29:0] == 30'h0))
    else $error("lower trigger register field wrong");

  chk_reset_fields: assert property (
    !written_any |-> (trig_upper == 32'h0000_0000) && (trig_lower == 32'h0000_0000))
    else $error("trigger fields not at reset value");

  chk_read_back: assert property (
    rd_take && (rd_addr == OFS_TRIG_UPPER) |=> (hrdata == trig_upper) && hreadyout)
    else $error("read of upper register returned wrong data");

  chk_sync_depth: assert property (
    (sync2 == $past(port_b_lines, 2)) && (prev == $past(sync2)))
    else $error("input synchroniser depth wrong");

  chk_irq_level: assert property (
    irq == |(status & mask))
    else $error("irq does not follow masked status");

  // bus side: zero wait states, always okay
  chk_ready_high: assert property (
    hreadyout)
    else $error("hreadyout dropped");

  chk_resp_okay: assert property (
    !hresp)
    else $error("hresp not okay");

  chk_read_lower: assert property (
    rd_take && (rd_addr == OFS_TRIG_LOWER)
      |=> (hrdata == trig_lower))
    else $error("read of lower register returned wrong data");

  chk_read_status: assert property (
    rd_take && (rd_addr == OFS_STATUS)
      |=> (hrdata == {status, 15'h0000}))
    else $error("read of status returned wrong data");

  chk_read_mask: assert property (
    rd_take && (rd_addr == OFS_MASK)
      |=> (hrdata == {mask, 15'h0000}))
    else $error("read of mask returned wrong data");

  chk_read_level: assert property (
    rd_take && (rd_addr == OFS_LEVEL)
      |=> (hrdata == {$past(sync2), 15'h0000}))
    else $error("read of pin level returned wrong data");

  chk_read_unmapped: assert property (
    rd_take && !rd_mapped
      |=> (hrdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  chk_no_read_zero: assert property (
    !rd_take
      |=> (hrdata == 32'h0000_0000))
    else $error("hrdata not zero outside a read");

  chk_write_no_rdata: assert property (
    take && hwrite
      |=> (hrdata == 32'h0000_0000))
    else $error("hrdata driven during a write");

  chk_aph_capture: assert property (
    take
      |=> aph.valid && (aph.addr == $past(rd_addr)))
    else $error("address phase not captured");

  chk_aph_idle: assert property (
    !take
      |=> !aph.valid)
    else $error("address phase held without a transfer");

  // registers change only when written
  chk_upper_hold: assert property (
    !wr_upper
      |=> (trig_upper == $past(trig_upper)))
    else $error("upper trigger register changed unwritten");

  chk_lower_hold: assert property (
    !wr_lower
      |=> (trig_lower == $past(trig_lower)))
    else $error("lower trigger register changed unwritten");

  chk_lower_unused: assert property (
    trig_lower[29:0] == 30'h0000_0000)
    else $error("lower register spare bits not zero");

  chk_mask_write: assert property (
    wr_mask
      |=> (mask == $past(wd_lines)))
    else $error("mask not written");

  chk_mask_hold: assert property (
    !wr_mask
      |=> (mask == $past(mask)))
    else $error("mask changed unwritten");

  // status is sticky; only a written one clears, and a new event wins
  chk_status_sticky: assert property (
    !wr_status
      |=> ((status & $past(status)) == $past(status)))
    else $error("status bit lost without a clear");

  chk_status_clear: assert property (
    wr_status && (want_any == '0)
      |=> (status == ($past(status) & ~$past(wd_lines))))
    else $error("status clear wrong");

  chk_set_beats_clear: assert property (
    wr_status && (|want_any)
      |=> ((status & $past(want_any)) == $past(want_any)))
    else $error("event lost to a clear in the same cycle");

  chk_status_cause: assert property (
    1'b1
      |=> ((status & ~$past(status) & ~$past(want_any)) == '0))
    else $error("status set without a trigger condition");

  chk_evt_match: assert property (
    evt == want_any)
    else $error("detector disagrees with trigger codes");

  chk_irq_masked_off: assert property (
    (mask == '0)
      |-> !irq)
    else $error("irq high with everything masked");

  chk_sync_first: assert property (
    sync1 == $past(port_b_lines))
    else $error("first synchroniser stage wrong");

endmodule : pbts_top

// >>> tb/tb.sv
// bench for pbts_top: trigger-select registers over ahb-lite, pin-driven interrupts
// assumes one ahb slave, so hready is looped back from hreadyout
`timescale 1ns/1ns
module tb;
  import pbts_pkg::*;
  logic         hclk, hresetn, hsel, hwrite, irq, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata, rd, wv;
  logic [1:0]   htrans, cd;
  logic [2:0]   hsize;
  logic [31:15] pins;
  int           err_count, checked, seed, ln;

  pbts_top u_pbts_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_b_lines(pins), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait: a stuck hreadyout ends the run instead of hanging it
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      complete_run();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  function automatic logic [11:0] tadr(input int l);
    return (l == 15) ? OFS_TRIG_LOWER : OFS_TRIG_UPPER;
  endfunction : tadr

  function automatic logic [31:0] fval(input int l, input logic [1:0] c);
    return (l == 15) ? {c, 30'h0} : (32'(c) << (2 * (l - 16)));
  endfunction : fval

  initial begin
    seed = 64;
    err_count = 0;
    checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pins = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, OFS_TRIG_UPPER, 32'h0);
    chk(rd, RST_TRIG_UPPER);
    bus(1'b0, OFS_TRIG_LOWER, 32'h0);
    chk(rd, RST_TRIG_LOWER);
    for (int i = 0; i < 20; i++) begin
      wv = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'hAAAA_AAAA : $random(seed);
      bus(1'b1, OFS_TRIG_UPPER, wv);
      bus(1'b0, OFS_TRIG_UPPER, 32'h0);
      chk(rd, wv);
      bus(1'b1, OFS_TRIG_LOWER, ~wv);
      bus(1'b0, OFS_TRIG_LOWER, 32'h0);
      chk(rd, ~wv & LOWER_RW_MASK);
    end
    bus(1'b0, 12'h250, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, OFS_TRIG_UPPER, 32'h0);
    bus(1'b1, OFS_TRIG_LOWER, 32'h0);
    // every code four times; the idle pin level of each code equals its low bit
    for (int i = 0; i < 16; i++) begin
      cd = i[1:0];
      ln = 15 + int'($unsigned($random(seed)) % 17);
      pins[ln] <= cd[0];
      bus(1'b1, tadr(ln), fval(ln, cd));
      bus(1'b1, OFS_MASK, 32'h1 << ln);
      bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      pins[ln] <= ~cd[0];
      repeat (5) @(posedge hclk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h1 << ln);
      bus(1'b0, OFS_LEVEL, 32'h0);
      chk(rd, {pins, 15'h0000});
      chk({31'h0, hresp}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd, cd[1] ? 32'h0 : (32'h1 << ln));
      bus(1'b1, OFS_MASK, 32'h0);
      bus(1'b0, OFS_MASK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, tadr(ln), 32'h0);
      pins[ln] <= 1'b0;
      repeat (5) @(posedge hclk);
      bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    end
    complete_run();
  end
endmodule : tb
